//--- rtl/asf_device.sv
`timescale 1ns/1ps
module asf_device (
    input  wire logic                         clk_sys,
    input  wire logic                         reset,
    asf_if.dev                                link,
    input  wire logic                         conv_clk,
    input  wire logic [asf_pkg::RES_W-1:0]    conv_code,
    input  wire logic                         conv_done,
    output logic                              conv_start,
    output logic [asf_pkg::CFG_MUX_MSB-asf_pkg::CFG_MUX_LSB:0] conv_mux_addr,
    output logic                              conv_unipolar,
    output logic                              select_seen
);
    import asf_pkg::*;

    localparam int unsigned MUX_W = CFG_MUX_MSB - CFG_MUX_LSB + 1;

    logic [3:0]           pin_s;
    logic                 aclk_s;
    logic                 cs_n_s;
    logic                 sclk_s;
    logic                 din_s;
    logic                 aclk_prev_q;
    logic                 sclk_prev_q;
    logic                 cs_n_valid_q;
    logic [1:0]           cs_cnt_q;
    asf_dev_state_e       state_q;
    asf_dev_state_e       state_d;
    logic [CNT_W-1:0]     bit_q;
    logic [CFG_W-1:0]     cfg_q;
    logic [CNT_W-1:0]     word_len_q;
    logic                 order_q;
    logic [RES_W-1:0]     res_q;
    logic                 res_uni_q;
    logic                 dout_q;
    logic                 dout_oe_q;
    logic                 conv_start_q;
    logic [MUX_W-1:0]     mux_q;
    logic                 uni_q;

    // Conversion clock, select, shift clock and data all come from outside.
    asf_sync #(
        .W   (4),
        .RST (4'h4)
    ) u_pin_sync (
        .clk_sys (clk_sys),
        .reset   (reset),
        .d       ({conv_clk, link.cs_n, link.sclk, link.din}),
        .q       (pin_s)
    );

    // Synchronised pin levels.
    assign aclk_s = pin_s[3];
    assign cs_n_s = pin_s[2];
    assign sclk_s = pin_s[1];
    assign din_s  = pin_s[0];

    // Edge detection on the synchronised clocks.
    wire aclk_fall = aclk_prev_q & ~aclk_s;
    wire sclk_rise = ~sclk_prev_q & sclk_s;
    wire sclk_fall = sclk_prev_q & ~sclk_s;
    wire cs_low    = ~cs_n_valid_q;

    // Transfer control decode.
    wire in_xfer    = (state_q == DEV_XFER) & cs_low;
    wire xfer_rise  = in_xfer & sclk_rise;
    wire xfer_fall  = in_xfer & sclk_fall & (bit_q != 5'h00);
    wire cfg_open   = bit_q < CFG_BITS;
    wire [CFG_W-1:0] cfg_next = {cfg_q[CFG_W-2:0], din_s};
    wire [CFG_W-1:0] cfg_fin  = (bit_q == CFG_BITS - 5'h01) ? cfg_next : cfg_q;
    wire [CNT_W-1:0] len_now  = asf_len(cfg_fin[CFG_LEN_HI_BIT], cfg_fin[CFG_LEN_LO_BIT]);
    wire [CNT_W-1:0] cur_len  = cfg_open ? len_now : word_len_q;
    wire [CNT_W-1:0] bit_inc  = bit_q + 5'h01;
    wire xfer_end   = xfer_rise & (bit_inc == cur_len);
    wire conv_fin   = (state_q == DEV_CONV) & conv_done;
    wire start_xfer = cs_low & ((state_q == DEV_IDLE) | conv_fin);

    // Formatting of a fresh result by the polarity of its own conversion.
    wire [RES_W-1:0] code_fmt = uni_q ? conv_code
                                      : {~conv_code[RES_W-1], conv_code[RES_W-2:0]};

    // Result bit sent in position k of the word.
    function automatic logic out_bit(input logic [CNT_W-1:0] k, input logic msb_first,
                                     input logic [RES_W-1:0] res, input logic uni);
        logic b;
        b = 1'b0;
        if (k >= CNT_W'(RES_W)) begin
            b = msb_first ? 1'b0 : (uni ? 1'b0 : res[RES_W-1]);
        end else if (msb_first) begin
            b = res[RES_W - 1 - int'(k)];
        end else begin
            b = res[k[3:0]];
        end
        return b;
    endfunction

    // State transitions.
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            DEV_IDLE: begin
                if (start_xfer) begin
                    state_d = DEV_XFER;
                end
            end
            DEV_XFER: begin
                if (!cs_low) begin
                    state_d = DEV_IDLE;
                end else if (xfer_end) begin
                    state_d = DEV_CONV;
                end
            end
            DEV_CONV: begin
                if (conv_fin) begin
                    state_d = cs_low ? DEV_XFER : DEV_IDLE;
                end
            end
            default: begin
                state_d = DEV_IDLE;
            end
        endcase
    end

    // Edge history of the synchronised clocks.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            aclk_prev_q <= 1'b0;
            sclk_prev_q <= 1'b0;
        end else begin
            aclk_prev_q <= aclk_s;
            sclk_prev_q <= sclk_s;
        end
    end

    // Select deglitcher: a new level must survive two conversion clock falls.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cs_n_valid_q <= 1'b1;
            cs_cnt_q     <= 2'h0;
        end else if (cs_n_s == cs_n_valid_q) begin
            cs_cnt_q <= 2'h0;
        end else if (aclk_fall) begin
            if (cs_cnt_q == DEGLITCH_EDGES - 2'h1) begin
                cs_n_valid_q <= cs_n_s;
                cs_cnt_q     <= 2'h0;
            end else begin
                cs_cnt_q <= cs_cnt_q + 2'h1;
            end
        end
    end

    // Bit counter and configuration capture.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_q    <= DEV_IDLE;
            bit_q      <= 5'h00;
            cfg_q      <= CFG_RST;
            word_len_q <= LEN_8;
        end else begin
            state_q <= state_d;
            if (start_xfer) begin
                bit_q <= 5'h00;
            end else if (xfer_rise) begin
                bit_q <= bit_inc;
                if (cfg_open) begin
                    cfg_q      <= cfg_next;
                    word_len_q <= len_now;
                end
            end
        end
    end

    // Conversion request, order for the next word, and latched result.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            conv_start_q <= 1'b0;
            mux_q        <= '0;
            uni_q        <= 1'b1;
            order_q      <= ORDER_RST;
            res_q        <= RES_RST;
            res_uni_q    <= 1'b1;
        end else begin
            conv_start_q <= xfer_end;
            if (xfer_end) begin
                mux_q   <= cfg_fin[CFG_MUX_MSB:CFG_MUX_LSB];
                uni_q   <= cfg_fin[CFG_UNI_BIT];
                order_q <= cfg_fin[CFG_ORDER_BIT];
            end
            if (conv_fin) begin
                res_q     <= code_fmt;
                res_uni_q <= uni_q;
            end
        end
    end

    // Result line: first bit on recognition, then one bit per falling edge.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            dout_q    <= 1'b0;
            dout_oe_q <= 1'b0;
        end else begin
            dout_oe_q <= cs_low & (start_xfer | (dout_oe_q & (state_q == DEV_XFER) & ~xfer_end));
            if (start_xfer) begin
                dout_q <= out_bit(5'h00, order_q, conv_fin ? code_fmt : res_q,
                                  conv_fin ? uni_q : res_uni_q);
            end else if (xfer_fall) begin
                dout_q <= out_bit(bit_q, order_q, res_q, res_uni_q);
            end
        end
    end

    // Outputs.
    assign link.dout     = dout_q;
    assign link.dout_oe  = dout_oe_q;
    assign conv_start    = conv_start_q;
    assign conv_mux_addr = mux_q;
    assign conv_unipolar = uni_q;
    assign select_seen   = cs_low;

endmodule

//--- rtl/asf_pkg.sv
package asf_pkg;

    // Configuration word layout; the word arrives first bit into bit 7.
    localparam int unsigned CFG_W          = 8;
    localparam int unsigned CFG_MUX_MSB    = 7;
    localparam int unsigned CFG_MUX_LSB    = 4;
    localparam int unsigned CFG_UNI_BIT    = 3;
    localparam int unsigned CFG_ORDER_BIT  = 2;
    localparam int unsigned CFG_LEN_HI_BIT = 1;
    localparam int unsigned CFG_LEN_LO_BIT = 0;

    // Result and output word widths.
    localparam int unsigned RES_W  = 10;
    localparam int unsigned WORD_W = 16;
    localparam int unsigned CNT_W  = 5;

    // Output word lengths selected by the two length bits.
    localparam logic [CNT_W-1:0] LEN_8  = 5'h08;
    localparam logic [CNT_W-1:0] LEN_10 = 5'h0A;
    localparam logic [CNT_W-1:0] LEN_12 = 5'h0C;
    localparam logic [CNT_W-1:0] LEN_16 = 5'h10;
    localparam logic [CNT_W-1:0] CFG_BITS = 5'h08;

    // Reset values.
    localparam logic [RES_W-1:0] RES_RST   = 10'h000;
    localparam logic [CFG_W-1:0] CFG_RST   = 8'h00;
    localparam logic             ORDER_RST = 1'b1;

    // Chip select is accepted after this many conversion clock falling edges.
    localparam logic [1:0] DEGLITCH_EDGES = 2'h2;

    // Timing of the controller end.
    localparam int unsigned CLK_PERIOD_NS  = 40;
    localparam int unsigned SCLK_PERIOD_NS = 320;
    localparam int unsigned ACLK_PERIOD_NS = 1000;
    localparam int unsigned CONV_TIME_NS   = 30000;
    localparam int unsigned SCLK_HALF_CYC  = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int unsigned CS_SETUP_CYC   = (3 * ACLK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 8;
    localparam int unsigned CS_HIGH_CYC    = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned TMR_W          = 12;

    // Device end states, Gray coded along idle, transfer, conversion.
    typedef enum logic [1:0] {
        DEV_IDLE = 2'b00,
        DEV_XFER = 2'b01,
        DEV_CONV = 2'b11
    } asf_dev_state_e;

    // Controller end states, Gray coded around the loop.
    typedef enum logic [1:0] {
        HST_IDLE  = 2'b00,
        HST_SETUP = 2'b01,
        HST_SHIFT = 2'b11,
        HST_HOLD  = 2'b10
    } asf_hst_state_e;

    // Word length in bits from the two length select bits.
    function automatic logic [CNT_W-1:0] asf_len(input logic length_select_high, input logic length_select_low);
        logic [CNT_W-1:0] len;
        len = LEN_8;
        unique case ({length_select_high, length_select_low})
            2'b00: len = LEN_8;
            2'b01: len = LEN_10;
            2'b10: len = LEN_12;
            2'b11: len = LEN_16;
        endcase
        return len;
    endfunction

endpackage

//--- rtl/asf_if.sv
`timescale 1ns/1ps
// Four-wire serial link between controller and converter port.
interface asf_if;
    logic cs_n;
    logic sclk;
    logic din;
    logic dout;
    logic dout_oe;
    wire  dout_line;

    // A released result line shows the inverse of the last bit, so a sample taken outside the word is caught.
    assign dout_line = dout_oe ? dout : ~dout;

    modport dev (
        input  cs_n,
        input  sclk,
        input  din,
        output dout,
        output dout_oe
    );

    modport hst (
        output cs_n,
        output sclk,
        output din,
        input  dout_line
    );
endinterface

//--- rtl/asf_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser, one bit per lane, with a constant reset value.
module asf_sync #(
    parameter int unsigned W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         clk_sys,
    input  wire logic         reset,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    // The first stage feeds only the second.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            meta_q <= RST;
            q      <= RST;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

//--- rtl/asf_host.sv
`timescale 1ns/1ps
// Controller end: sends one configuration word and collects the result word.
module asf_host (
    input  wire logic                       clk_sys,
    input  wire logic                       reset,
    asf_if.hst                              link,
    input  wire logic                       start,
    input  wire logic [asf_pkg::CFG_W-1:0]  cfg_word,
    output logic                            busy,
    output logic [asf_pkg::WORD_W-1:0]      rx_word,
    output logic                            rx_valid
);
    import asf_pkg::*;

    asf_hst_state_e      state_q;
    logic [TMR_W-1:0]    tmr_q;
    logic                cs_n_q;
    logic                sclk_q;
    logic [CFG_W-1:0]    tx_q;
    logic [CNT_W-1:0]    len_q;
    logic [CNT_W-1:0]    rise_q;
    logic [WORD_W-1:0]   rx_q;
    logic                rx_valid_q;
    logic                dout_s;

    // The result line comes from outside this clock's domain.
    asf_sync #(
        .W   (1),
        .RST (1'b0)
    ) u_dout_sync (
        .clk_sys (clk_sys),
        .reset   (reset),
        .d       (link.dout_line),
        .q       (dout_s)
    );

    // Timer expiry per state.
    wire half_done  = tmr_q == TMR_W'(SCLK_HALF_CYC - 1);
    wire setup_done = tmr_q == TMR_W'(CS_SETUP_CYC - 1);
    wire hold_done  = tmr_q == TMR_W'(CS_HIGH_CYC - 1);
    wire last_fall  = half_done & sclk_q & (rise_q == len_q);

    // Sequencer: select, deglitch wait, clocking, then select high for the conversion.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_q    <= HST_IDLE;
            tmr_q      <= '0;
            cs_n_q     <= 1'b1;
            sclk_q     <= 1'b0;
            tx_q       <= CFG_RST;
            len_q      <= LEN_8;
            rise_q     <= 5'h00;
            rx_q       <= '0;
            rx_valid_q <= 1'b0;
        end else begin
            rx_valid_q <= 1'b0;
            tmr_q      <= tmr_q + TMR_W'(1);
            unique case (state_q)
                HST_IDLE: begin
                    tmr_q <= '0;
                    if (start) begin
                        state_q <= HST_SETUP;
                        cs_n_q  <= 1'b0;
                        tx_q    <= cfg_word;
                        len_q   <= asf_len(cfg_word[CFG_LEN_HI_BIT], cfg_word[CFG_LEN_LO_BIT]);
                        rise_q  <= 5'h00;
                        rx_q    <= '0;
                    end
                end
                HST_SETUP: begin
                    if (setup_done) begin
                        state_q <= HST_SHIFT;
                        tmr_q   <= '0;
                    end
                end
                HST_SHIFT: begin
                    if (half_done) begin
                        tmr_q <= '0;
                        if (!sclk_q) begin
                            sclk_q <= 1'b1;
                            rise_q <= rise_q + 5'h01;
                        end else begin
                            sclk_q <= 1'b0;
                            rx_q   <= {rx_q[WORD_W-2:0], dout_s};
                            tx_q   <= {tx_q[CFG_W-2:0], 1'b0};
                            if (last_fall) begin
                                state_q    <= HST_HOLD;
                                cs_n_q     <= 1'b1;
                                rx_valid_q <= 1'b1;
                            end
                        end
                    end
                end
                HST_HOLD: begin
                    if (hold_done) begin
                        state_q <= HST_IDLE;
                    end
                end
            endcase
        end
    end

    // Outputs; configuration goes out first bit first.
    assign link.cs_n = cs_n_q;
    assign link.sclk = sclk_q;
    assign link.din  = tx_q[CFG_W-1];
    assign busy      = state_q != HST_IDLE;
    assign rx_word   = rx_q;
    assign rx_valid  = rx_valid_q;

endmodule

//--- dv/asf_asserts.sv
`timescale 1ns/1ps
// Link checker; watches the four wires and the result line enable.
module asf_asserts (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    input wire logic dout,
    input wire logic dout_oe
);
    logic       sclk_q;
    logic       cs_n_q;
    logic       output_order_select_q;
    logic [4:0] cnt_q;
    logic [7:0] cfg_q;
    wire        sclk_rise;
    wire        cs_rise;
    wire  [1:0] len_sel;
    wire  [4:0] len_now;

    // Edge finders and the length that the word in flight selects.
    assign sclk_rise = sclk & ~sclk_q;
    assign cs_rise   = cs_n & ~cs_n_q;
    assign len_sel   = (cnt_q < 5'h08) ? {cfg_q[0], din} : cfg_q[1:0];
    assign len_now   = (len_sel == 2'h0) ? 5'h08 : (len_sel == 2'h1) ? 5'h0A : (len_sel == 2'h2) ? 5'h0C : 5'h10;

    // Count rising shift edges, gather the word and track the order bit.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
            cnt_q  <= 5'h00;
            cfg_q  <= 8'h00;
            output_order_select_q <= 1'b1;
        end else begin
            sclk_q <= sclk;
            cs_n_q <= cs_n;
            cnt_q  <= cs_n ? 5'h00 : (sclk_rise ? cnt_q + 5'h01 : cnt_q);
            cfg_q  <= (sclk_rise && !cs_n && cnt_q < 5'h08) ? {cfg_q[6:0], din} : cfg_q;
            output_order_select_q <= (cs_rise && cnt_q >= 5'h08) ? cfg_q[2] : output_order_select_q;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    // The rising edge that completes the word, and the released result line.
    sequence s_final_rise;
        sclk_rise && !cs_n && (cnt_q + 5'h01 == len_now);
    endsequence
    sequence s_oe_low;
        !dout_oe;
    endsequence

    oe_on_select_a: assert property ($rose(dout_oe) |-> !cs_n)
        else $error("result line driven without select");
    early_oe_a: assert property ($fell(cs_n) |-> !dout_oe [*8])
        else $error("select accepted too early");
    oe_drop_a: assert property ($rose(cs_n) |-> ##[0:40] s_oe_low)
        else $error("result line still driven after select high");
    oe_release_a: assert property (cs_n && !dout_oe |=> !dout_oe)
        else $error("result line driven while select high");
    final_rise_a: assert property (s_final_rise |-> ##[1:6] s_oe_low)
        else $error("result line not released after last bit");
    oe_hold_a: assert property (sclk_rise && !cs_n && (cnt_q + 5'h01 < len_now) |-> dout_oe)
        else $error("result line released inside the word");
    pad_msb_a: assert property (sclk_rise && !cs_n && output_order_select_q && cnt_q >= 5'h0A |-> !dout)
        else $error("padding bit not zero");
    launch_fall_a: assert property (dout_oe && $past(dout_oe) && $changed(dout) |-> !sclk)
        else $error("result bit changed while shift clock high");
    din_launch_a: assert property ($changed(din) |-> !sclk)
        else $error("data in changed while shift clock high");
    sclk_count_a: assert property (cs_rise && cnt_q != 5'h00 |-> cnt_q == len_now)
        else $error("shift clock count differs from word length");
endmodule

//--- dv/test_adc_serial_result_formatter.sv
`timescale 1ns/1ps
module test_adc_serial_result_formatter;
    import asf_pkg::*;
    logic                                 clk_sys;
    logic                                 reset;
    logic                                 conv_clk;
    logic                                 conv_done;
    logic                                 conv_start;
    logic                                 conv_unipolar;
    logic                                 select_seen;
    logic                                 start;
    logic                                 busy;
    logic                                 rx_valid;
    logic [RES_W-1:0]                     conv_code;
    logic [CFG_W-1:0]                     cfg_word;
    logic [CFG_MUX_MSB-CFG_MUX_LSB:0]     conv_mux_addr;
    logic [WORD_W-1:0]                    rx_word;
    logic [31:0]                          lfsr_q;
    logic [RES_W-1:0]                     exp_code;
    logic                                 exp_uni;
    logic                                 exp_output_order_select;
    int                                   conv_wait;
    int                                   error_cnt;
    int                                   checked;

    asf_if link();

    asf_device i_asf_device (.clk_sys(clk_sys), .reset(reset), .link(link), .conv_clk(conv_clk),
        .conv_code(conv_code), .conv_done(conv_done), .conv_start(conv_start),
        .conv_mux_addr(conv_mux_addr), .conv_unipolar(conv_unipolar), .select_seen(select_seen));
    asf_host i_asf_host (.clk_sys(clk_sys), .reset(reset), .link(link), .start(start), .cfg_word(cfg_word),
        .busy(busy), .rx_word(rx_word), .rx_valid(rx_valid));
    asf_asserts i_asf_asserts (.clk_sys(clk_sys), .reset(reset), .cs_n(link.cs_n), .sclk(link.sclk),
        .din(link.din), .dout(link.dout), .dout_oe(link.dout_oe));

    // System clock and a conversion clock of unrelated phase.
    always #20 clk_sys = ~clk_sys;
    initial begin
        conv_clk = 1'b0;
        #7;
        forever #160 conv_clk = ~conv_clk;
    end

    // Converter core stand-in: answers each start with a done pulse, long after select is seen high again.
    always @(posedge clk_sys) begin
        conv_done <= 1'b0;
        if (conv_wait > 0) begin
            conv_wait = conv_wait - 1;
            if (conv_wait == 1) conv_done <= 1'b1;
        end else if (conv_start === 1'b1) begin
            conv_wait = 200;
        end
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Expected received word, first bit in the highest used place.
    function automatic logic [WORD_W-1:0] exp_word(input logic [RES_W-1:0] code, input logic uni,
                                                   input logic output_order_select, input logic [1:0] ls);
        logic [RES_W-1:0]  r;
        logic [WORD_W-1:0] w;
        logic              b;
        int                n;
        r = uni ? code : {~code[RES_W-1], code[RES_W-2:0]};
        n = (ls == 2'h0) ? 8 : (ls == 2'h1) ? 10 : (ls == 2'h2) ? 12 : 16;
        w = '0;
        for (int k = 0; k < n; k++) begin
            if (k >= 10) b = (output_order_select || uni) ? 1'b0 : r[RES_W-1];
            else b = output_order_select ? r[RES_W-1-k] : r[k];
            w = {w[WORD_W-2:0], b};
        end
        return w;
    endfunction

    task automatic check_word(input string name, input logic [WORD_W-1:0] exp, input logic [WORD_W-1:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // One full transfer, then the conversion that it requests.
    task automatic xfer(input logic [CFG_W-1:0] cfg, input logic [RES_W-1:0] code);
        int t;
        @(posedge clk_sys);
        start     <= 1'b1;
        cfg_word  <= cfg;
        conv_code <= code;
        @(posedge clk_sys);
        start <= 1'b0;
        t = 0;
        // Outputs are looked at on the falling edge, where they have settled.
        while (rx_valid !== 1'b1 && t < 3000) begin
            @(negedge clk_sys);
            t++;
        end
        if (t >= 3000) begin
            error_cnt++;
            stop_test();
        end
        check_word("rx_word", exp_word(exp_code, exp_uni, exp_output_order_select, cfg[1:0]), rx_word);
        check_word("select_seen", 16'h0001, {15'h0000, select_seen});
        t = 0;
        while (busy !== 1'b0 && t < 3000) begin
            @(negedge clk_sys);
            t++;
        end
        if (t >= 3000) begin
            error_cnt++;
            stop_test();
        end
        check_word("select_seen", 16'h0000, {15'h0000, select_seen});
        check_word("unipolar", {15'h0000, cfg[CFG_UNI_BIT]}, {15'h0000, conv_unipolar});
        check_word("mux", {12'h000, cfg[7:4]}, {12'h000, conv_mux_addr});
        exp_code = code;
        exp_uni  = cfg[CFG_UNI_BIT];
        exp_output_order_select = cfg[CFG_ORDER_BIT];
    endtask

    // Watchdog sized from about a thousand cycles per transfer.
    initial begin
        repeat (40000) @(posedge clk_sys);
        error_cnt++;
        stop_test();
    end

    // Reset, then a sweep of every length, order and polarity, then random words.
    initial begin
        logic [RES_W-1:0] corner [6];
        logic [CFG_W-1:0] cfg;
        logic [RES_W-1:0] code;
        corner    = '{10'h3FF, 10'h3FE, 10'h000, 10'h001, 10'h200, 10'h1FF};
        clk_sys   = 1'b0;
        reset     = 1'b1;
        start     = 1'b0;
        cfg_word  = 8'h00;
        conv_code = 10'h000;
        conv_done = 1'b0;
        conv_wait = 0;
        error_cnt = 0;
        checked   = 0;
        lfsr_q    = 32'h6A0C;
        exp_code  = RES_RST;
        exp_uni   = 1'b1;
        exp_output_order_select  = ORDER_RST;
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        for (int i = 0; i < 24; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            cfg    = (i < 16) ? {lfsr_q[7:4], i[3], i[2], i[1:0]} : lfsr_q[CFG_W-1:0];
            code   = (i < 6) ? corner[i] : lfsr_q[RES_W+7:8];
            xfer(cfg, code);
        end
        stop_test();
    end
endmodule
